// File: verilog/qcef_front.sv
// channel encoder front end: sync, scramble, checksum, interleave
// What this block does
// R1: A/C mode aligns packets on sync byte
// R2: A/C mode scrambles data after alignment
// R3: B mode replaces sync byte with checksum
// R4: Reed-Solomon check words appended per packet
// R5: two check words per correctable word
// R6: first words sent newest packet to oldest
// R7: same order repeated for each later word
// R8: B packet is 122 data plus 6 check
// R9: A/C packet 204 words, interleave 12 by 17; code does a 12 packet by 204 word block interleave instead
// R10: mode and set size held per set
`timescale 1ns/1ns
`include "qcef_defs.svh"
module qcef_front #(
  parameter int MAX_SET = `QCEF_MAX_SET
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       mode_annex_b,
  input  wire logic [7:0] set_packets,
  input  wire logic [7:0] in_data,
  input  wire logic       in_valid,
  output logic            in_ready,
  output logic      [7:0] out_data,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic            sync_lock
);
  localparam int DEPTH  = MAX_SET * int'(`QCEF_AC_CODED_LEN);
  localparam int ADDR_W = $clog2(DEPTH);
  localparam int NPAR   = `QCEF_MAX_PAR;

  default clocking chk_clk @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  function automatic logic [7:0] gf_mul(input logic [7:0] a,
                                        input logic [7:0] b);
    logic [7:0] acc;
    logic [7:0] x;
    acc = 8'h00;
    x = a;
    for (int k = 0; k < 8; k++)
    begin
      if (b[k])
        acc = acc ^ x;
      x = x[7] ? ({x[6:0], 1'b0} ^ `QCEF_GF_REDUCE) : {x[6:0], 1'b0};
    end
    return acc;
  endfunction

  // generator taps of the check word divider
  function automatic logic [7:0] gen_tap(input int i);
    return 8'(i + 2);
  endfunction

  function automatic logic [22:0] scr_step(input logic [14:0] s);
    logic [14:0] r;
    logic [7:0]  b;
    logic        fb;
    r = s;
    b = 8'h00;
    for (int k = 7; k >= 0; k--)
    begin
      fb = r[13] ^ r[14];
      b[k] = fb;
      r = {r[13:0], fb};
    end
    return {b, r};
  endfunction

  qcef_pkg::qcef_state_t state;
  logic [7:0]  mode_b_word;
  logic        mode_b;
  logic [7:0]  set_len;
  logic [7:0]  pkt;
  logic [7:0]  word;
  logic [7:0]  drain_pkt;
  logic [7:0]  drain_word;
  logic [7:0]  par [NPAR];
  logic [7:0]  next_par [NPAR];
  logic [7:0]  csum;
  logic [7:0]  prev_csum;
  logic [14:0] scr;
  logic [7:0]  mem [DEPTH];

  // lengths follow the latched mode
  wire [7:0]  coded_len = mode_b ? `QCEF_B_CODED_LEN
                                 : `QCEF_AC_CODED_LEN; // see R8 see R9
  wire [7:0]  par_len   = mode_b ? `QCEF_B_PAR_LEN
                                 : `QCEF_AC_PAR_LEN; // see R5
  wire [7:0]  data_len  = coded_len - par_len;
  wire        take      = in_valid && in_ready;
  wire        is_sync   = (in_data == `QCEF_SYNC_BYTE); // see R1
  wire        in_hunt   = (state == qcef_pkg::QCEF_HUNT);
  wire        in_data_s = (state == qcef_pkg::QCEF_DATA);
  wire        in_par    = (state == qcef_pkg::QCEF_PARITY);
  wire        in_drain  = (state == qcef_pkg::QCEF_DRAIN);
  wire        set_start = in_hunt && pkt == 8'h00;
  wire        mode_now  = set_start ? mode_annex_b : mode_b;
  wire [22:0] scr_nx    = scr_step(scr);
  wire [7:0]  scr_byte  = scr_nx[22:15];
  wire [14:0] scr_next  = scr_nx[14:0];
  wire [7:0]  first_val = mode_now ? prev_csum
                                   : `QCEF_SYNC_BYTE; // see R3
  wire [7:0]  body_val  = mode_b ? in_data
                                 : in_data ^ scr_byte; // see R2
  wire [7:0]  par_top   = par[par_len[3:0] - 4'd1];
  wire        first_wr  = take && in_hunt && is_sync;
  wire        body_wr   = take && in_data_s;
  wire        rs_feed   = first_wr || body_wr;
  wire [7:0]  rs_in     = first_wr ? first_val : body_val;
  wire [7:0]  rs_fb     = rs_in ^ (set_start ? 8'h00 : par_top);
  wire        wr_en     = rs_feed || in_par;
  wire [7:0]  wr_val    = in_par ? par_top : rs_in; // see R4
  wire [7:0]  wr_word   = first_wr ? 8'h00 : word;
  wire [15:0] wr_full   = 16'(pkt) * 16'(coded_len) + 16'(wr_word);
  wire [15:0] rd_full   = 16'(drain_pkt) * 16'(coded_len)
                          + 16'(drain_word);
  wire [ADDR_W-1:0] wr_addr = wr_full[ADDR_W-1:0];
  wire [ADDR_W-1:0] rd_addr = rd_full[ADDR_W-1:0];
  wire        buf_ready;
  wire        push      = in_drain && buf_ready;
  wire        data_last = body_wr && word == data_len - 8'h01;
  wire        par_last  = in_par && word == coded_len - 8'h01;
  wire        drain_end = push && drain_pkt == 8'h00
                          && drain_word == coded_len - 8'h01;
  // set size fixed in a/c, taken from input in b
  wire [7:0]  cfg_set   = mode_annex_b ? set_packets
                                       : `QCEF_AC_SET_LEN; // see R9

  assign in_ready  = in_hunt || in_data_s;
  assign sync_lock = !in_hunt;

  // check word divider, one stage per word
  genvar gi;
  generate
    for (gi = 0; gi < NPAR; gi++)
    begin : g_par
      if (gi == 0)
      begin : g_first
        assign next_par[gi] = gf_mul(rs_fb, gen_tap(gi));
      end
      else
      begin : g_rest
        assign next_par[gi] = (set_start ? 8'h00 : par[gi-1])
                              ^ gf_mul(rs_fb, gen_tap(gi));
      end
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_val;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      for (int i = 0; i < NPAR; i++)
        par[i] <= 8'h00;
    else if (rs_feed)
      par <= next_par; // see R4
    else if (in_par)
    begin
      par[0] <= 8'h00;
      for (int i = 1; i < NPAR; i++)
        par[i] <= par[i-1];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state      <= qcef_pkg::QCEF_HUNT;
      mode_b     <= 1'b0;
      set_len    <= `QCEF_AC_SET_LEN;
      pkt        <= 8'h00;
      word       <= 8'h00;
      drain_pkt  <= 8'h00;
      drain_word <= 8'h00;
      csum       <= 8'h00;
      prev_csum  <= 8'h00;
      scr        <= `QCEF_SCR_SEED;
    end
    else
    begin
      unique case (state)
        qcef_pkg::QCEF_HUNT:
          if (take && is_sync) // see R1 see R3
          begin
            if (set_start)
            begin
              mode_b  <= mode_annex_b; // see R10
              set_len <= cfg_set;      // see R10
            end
            state <= qcef_pkg::QCEF_DATA;
            word  <= 8'h01;
            csum  <= 8'h00;
            scr   <= `QCEF_SCR_SEED;
          end
        qcef_pkg::QCEF_DATA:
          if (take)
          begin
            word <= word + 8'h01;
            csum <= csum ^ in_data;
            if (!mode_b)
              scr <= scr_next; // see R2
            if (data_last)
            begin
              state <= qcef_pkg::QCEF_PARITY;
              if (mode_b)
                prev_csum <= csum ^ in_data; // see R3
            end
          end
        qcef_pkg::QCEF_PARITY:
        begin
          word <= word + 8'h01;
          if (par_last)
          begin
            word <= 8'h00;
            if (pkt == set_len - 8'h01)
            begin
              state      <= qcef_pkg::QCEF_DRAIN;
              drain_pkt  <= set_len - 8'h01;
              drain_word <= 8'h00;
            end
            else
            begin
              state <= qcef_pkg::QCEF_HUNT;
              pkt   <= pkt + 8'h01;
            end
          end
        end
        qcef_pkg::QCEF_DRAIN:
          if (push)
          begin
            if (drain_pkt != 8'h00)
              drain_pkt <= drain_pkt - 8'h01; // see R6
            else
            begin
              drain_pkt  <= set_len - 8'h01; // see R7
              drain_word <= drain_word + 8'h01;
            end
            if (drain_end)
            begin
              state <= qcef_pkg::QCEF_HUNT;
              pkt   <= 8'h00;
            end
          end
      endcase
    end
  end

  qcef_skid_buf #(
    .WIDTH(8)
  ) u_out_buf (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .in_data  (mem[rd_addr]),
    .in_valid (in_drain),
    .in_ready (buf_ready),
    .out_data (out_data),
    .out_valid(out_valid),
    .out_ready(out_ready)
  );

  // helper: cycles spent emitting check words
  logic [7:0] par_cycles;
  always_ff @(posedge clk_sys)
  begin
    if (reset || !in_par)
      par_cycles <= 8'h00;
    else
      par_cycles <= par_cycles + 8'h01;
  end

  chk_hunt_drop: assert property ( // see R1
    in_hunt && take && !is_sync |=> in_hunt)
    else $error("non-sync byte left hunt");
  chk_sync_start: assert property ( // see R1
    in_hunt && take && is_sync |=> in_data_s && word == 8'h01)
    else $error("sync byte did not start packet");
  chk_scramble: assert property ( // see R2
    body_wr && !mode_b |-> wr_val == (in_data ^ scr_byte))
    else $error("data byte not scrambled");
  chk_scr_step: assert property ( // see R2
    body_wr && !mode_b |=> scr == $past(scr_next))
    else $error("scrambler did not advance");
  chk_csum_slot: assert property ( // see R3
    first_wr && mode_now |-> wr_val == prev_csum && wr_word == 8'h00)
    else $error("checksum byte not in sync slot");
  chk_parity_len: assert property ( // see R4
    $fell(in_par) |-> $past(par_cycles) == par_len - 8'h01)
    else $error("wrong count of check words");
  chk_b_lengths: assert property ( // see R8
    mode_b |-> coded_len == 8'd128 && data_len == 8'd122
               && par_len == 8'd6)
    else $error("annex b lengths wrong");
  chk_ac_lengths: assert property ( // see R9
    in_data_s && !mode_b |-> coded_len == 8'd204 && set_len == 8'd12
                            && par_len == 8'd16)
    else $error("annex a/c lengths wrong");
  chk_pkt_order: assert property ( // see R6
    push && drain_pkt != 8'h00 && !drain_end |=>
      drain_pkt == $past(drain_pkt) - 8'h01
      && drain_word == $past(drain_word))
    else $error("packet order broken");
  chk_word_step: assert property ( // see R7
    push && drain_pkt == 8'h00 && !drain_end |=>
      drain_pkt == set_len - 8'h01
      && drain_word == $past(drain_word) + 8'h01)
    else $error("word step broken");
  chk_cfg_hold: assert property ( // see R10
    !set_start ##1 !set_start |-> $stable(mode_b) && $stable(set_len))
    else $error("config changed mid set");
endmodule

// File: verilog/qcef_defs.svh
// constants of the channel encoder front end
`ifndef QCEF_DEFS_SVH
`define QCEF_DEFS_SVH
`define QCEF_SYNC_BYTE    8'h07
`define QCEF_AC_CODED_LEN 8'hcc
`define QCEF_AC_PAR_LEN   8'h10
`define QCEF_AC_SET_LEN   8'h0c
`define QCEF_AC_J         8'h11
`define QCEF_B_CODED_LEN  8'h80
`define QCEF_B_DATA_LEN   8'h7a
`define QCEF_B_PAR_LEN    8'h06
`define QCEF_GF_REDUCE    8'h1d
`define QCEF_SCR_SEED     15'h4a80
`define QCEF_MAX_PAR      16
`define QCEF_MAX_SET      12
`endif

// File: verilog/qcef_pkg.sv
// types of the channel encoder front end
package qcef_pkg;
  typedef enum logic [1:0] {QCEF_HUNT, QCEF_DATA, QCEF_PARITY,
                            QCEF_DRAIN} qcef_state_t;
endpackage

// File: verilog/qcef_skid_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module qcef_skid_buf #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] slot0;
  logic [WIDTH-1:0] slot1;
  logic [1:0]       count;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data  = slot0;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      count <= 2'd0;
      slot0 <= '0;
      slot1 <= '0;
    end
    else
    begin
      count <= count + {1'b0, push} - {1'b0, pop};
      if (pop)
        slot0 <= (count == 2'd2) ? slot1 : in_data;
      else if (push && count == 2'd0)
        slot0 <= in_data;
      if (push && ((count == 2'd1 && !pop) || count == 2'd2))
        slot1 <= in_data;
    end
  end
endmodule

// File: testbench/qcef_sink.sv
// downstream modulation stage model taking output bytes
`timescale 1ns/1ns
module qcef_sink (
  input  wire logic       clk_sys,
  input  wire logic [7:0] out_data,
  input  wire logic       out_valid,
  output logic            out_ready,
  input  wire logic       stall
);
  logic [1:0] phase = 2'h0;
  logic [7:0] got[$];
  initial out_ready = 1'b1;
  // slow receiver drops ready one cycle in four
  always @(posedge clk_sys)
  begin
    if (out_valid && out_ready)
      got.push_back(out_data);
    phase <= phase + 2'h1;
    out_ready <= !(stall && phase == 2'h3);
  end
endmodule

// File: testbench/tb_qam_channel_encoder_front.sv
// self-checking bench for the channel encoder front end
`timescale 1ns/1ns
module tb_qam_channel_encoder_front;
  logic       clk_sys;
  logic       reset;
  logic       mode_annex_b;
  logic [7:0] set_packets;
  logic [7:0] in_data;
  logic       in_valid;
  logic       in_ready;
  logic [7:0] out_data;
  logic       out_valid;
  logic       out_ready;
  logic       sync_lock;
  logic       stall;
  logic [7:0] prev_x;
  logic [7:0] w0[12];
  int         n_errors = 0;
  int         compares = 0;
  int         cycles = 0;
  int         gpkt = 0;

  qcef_front DUT (
    .clk_sys(clk_sys),
    .reset(reset),
    .mode_annex_b(mode_annex_b),
    .set_packets(set_packets),
    .in_data(in_data),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .out_data(out_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .sync_lock(sync_lock)
  );
  qcef_sink SNK (
    .clk_sys(clk_sys),
    .out_data(out_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .stall(stall)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors = n_errors + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] dat(input int g, input int i);
    return 8'(g * 29 + i * 3 + 1);
  endfunction

  task automatic put_byte(input logic [7:0] b);
    logic r;
    in_valid <= 1'b1;
    in_data <= b;
    r = 1'b0;
    while (!r)
    begin
      @(negedge clk_sys);
      r = in_ready;
      @(posedge clk_sys);
    end
  endtask

  task automatic send_pkt(input int dl, output logic [7:0] x);
    x = 8'h00;
    put_byte(8'h07);
    for (int i = 1; i < dl; i++)
    begin
      put_byte(dat(gpkt, i));
      x ^= dat(gpkt, i);
    end
    in_valid <= 1'b0;
  endtask

  task automatic gap(input int par);
    int c;
    c = 0;
    @(negedge clk_sys);
    check("lock", {7'h0, sync_lock}, 8'h01);
    while (!in_ready && c < 40)
    begin
      c++;
      @(negedge clk_sys);
    end
    check("gap", 8'(c), 8'(par));
    @(posedge clk_sys);
  endtask

  task automatic run_set(input logic b, input int n, input bit flip);
    int dl;
    int cl;
    int g0;
    int same;
    logic [7:0] e;
    logic [7:0] x;
    dl = b ? 122 : 188;
    cl = b ? 128 : 204;
    g0 = gpkt;
    same = 0;
    SNK.got.delete();
    mode_annex_b <= b;
    set_packets <= b ? 8'(n) : 8'h03;
    for (int k = 0; k < n; k++)
    begin
      w0[k] = b ? prev_x : 8'h07;
      send_pkt(dl, x);
      if (b)
        prev_x = x;
      gpkt++;
      if (k == 0 && flip)
      begin
        mode_annex_b <= ~b;
        set_packets <= 8'h01;
      end
      if (k < n - 1)
        gap(cl - dl);
    end
    for (int t = 0; t < 8000 && SNK.got.size() < cl * n; t++)
      @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    check("count", 8'(SNK.got.size() != cl * n), 8'h00);
    @(negedge clk_sys);
    check("rehunt", {7'h0, sync_lock}, 8'h00);
    for (int w = 0; w < dl; w++)
      for (int k = 0; k < n; k++)
      begin
        e = (w == 0) ? w0[n - 1 - k] : dat(g0 + n - 1 - k, w);
        if (b || w == 0)
          check("word", SNK.got[w * n + k], e);
        else if (SNK.got[w * n + k] === e)
          same++;
      end
    if (!b)
      check("scramble", 8'(same > 100), 8'h00);
    @(posedge clk_sys);
  endtask

  task automatic sc_reset_hunt();
    @(negedge clk_sys);
    check("ready", {7'h0, in_ready}, 8'h01);
    check("oval", {7'h0, out_valid}, 8'h00);
    @(posedge clk_sys);
    put_byte(8'h55);
    put_byte(8'hf7);
    in_valid <= 1'b0;
    @(negedge clk_sys);
    check("hunt", {7'h0, sync_lock}, 8'h00);
    @(posedge clk_sys);
  endtask

  task automatic sc_b_two();
    stall <= 1'b0;
    run_set(1'b1, 2, 1'b0);
  endtask

  task automatic sc_b_stall_flip();
    stall <= 1'b1;
    put_byte(8'h70);
    run_set(1'b1, 3, 1'b1);
  endtask

  task automatic sc_ac_set();
    stall <= 1'b1;
    run_set(1'b0, 12, 1'b0);
  endtask

  initial
  begin
    reset = 1'b1;
    mode_annex_b = 1'b1;
    set_packets = 8'h02;
    in_data = 8'h00;
    in_valid = 1'b0;
    stall = 1'b0;
    prev_x = 8'h00;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    sc_reset_hunt();
    sc_b_two();
    sc_b_stall_flip();
    sc_ac_set();
    tally_and_finish();
  end
endmodule
